// ---- hw/fni_top.sv ----
// Fractional-N divide-ratio controller with AXI4-Lite register access
// Function
// - Third-order modulator; modulus any integer 2 to 4095 in twelve bits.
// - Modulator steps once per phase detector cycle.
// - Average divide ratio equals integer part plus numerator over modulus.
// - Without dither the sequence repeats after 1, 2, 3 or 6 moduli.
// - With dither the sequence repeats after 2^21 cycles.
// - Dither off in both noise modes, on only in low spur mode.
// - Fastlock set forces maximum charge pump current.
// - Host selects switch function on mux output; switch closes during fastlock.
// - Fastlock cleared restores programmed current and opens the switch.
// - Doubler on doubles reference rate before divider and detector.
// - Same channel always gives the same spur pattern.
// - Reference divided by 1 to 15 to form the detector clock.
// - Doubler bit 0 bypasses, bit 1 doubles.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "fni_defines.svh"
module fni_top (
	input  wire logic        MCLK_IN,
	input  wire logic        NRST_IN,
	input  wire logic [7:0]  S_AXI_AWADDR_IN,
	input  wire logic        S_AXI_AWVALID_IN,
	output logic             S_AXI_AWREADY_OUT,
	input  wire logic [31:0] S_AXI_WDATA_IN,
	input  wire logic [3:0]  S_AXI_WSTRB_IN,
	input  wire logic        S_AXI_WVALID_IN,
	output logic             S_AXI_WREADY_OUT,
	output logic [1:0]       S_AXI_BRESP_OUT,
	output logic             S_AXI_BVALID_OUT,
	input  wire logic        S_AXI_BREADY_IN,
	input  wire logic [7:0]  S_AXI_ARADDR_IN,
	input  wire logic        S_AXI_ARVALID_IN,
	output logic             S_AXI_ARREADY_OUT,
	output logic [31:0]      S_AXI_RDATA_OUT,
	output logic [1:0]       S_AXI_RRESP_OUT,
	output logic             S_AXI_RVALID_OUT,
	input  wire logic        S_AXI_RREADY_IN,
	input  wire logic        REFERENCE_INPUT_IN,
	output logic [15:0]      DIV_RATIO_OUT,
	output logic             PFD_TICK_OUT,
	output logic [3:0]       CP_CURRENT_OUT,
	output logic             FL_SWITCH_OUT,
	output logic             MULTIPLEXED_OUTPUT_OUT
);
	fni_pkg::fni_top_state_t st_q;
	fni_pkg::fni_top_state_t st_d;

	logic [11:0] res1;
	logic [11:0] res2;
	logic [11:0] res3;
	logic        c1;
	logic        c2;
	logic        c3;
	logic        dither_en;
	logic        dither_bit;
	logic [11:0] stage3_add;
	logic [4:0]  ysum;
	logic        ref_event;
	logic [3:0]  rdiv_eff;
	logic [3:0]  cp_eff;
	logic        sw_closed;
	logic [31:0] wmask;
	logic [31:0] merged;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [11:0] mod_load;
	logic        wr_fire;

	// Dither only in the low spur mode
	assign dither_en = (st_q.mode == fni_pkg::FNI_LOW_SPUR);
	// Residual of stage two is below the modulus, so adding one bit never overflows
	assign stage3_add = res2 + {11'h000, dither_bit};

	// Three cascaded first-order stages form the third-order modulator
	fni_accum u_acc1 (
		.clk_in      (MCLK_IN),
		.rst_n_in    (NRST_IN),
		.clr_in      (st_q.load),
		.step_in     (st_q.tick),
		.modulus_in  (st_q.mod_act),
		.add_in      (st_q.fractional_numerator),
		.res_nxt_out (res1),
		.carry_out   (c1)
	);

	fni_accum u_acc2 (
		.clk_in      (MCLK_IN),
		.rst_n_in    (NRST_IN),
		.clr_in      (st_q.load),
		.step_in     (st_q.tick),
		.modulus_in  (st_q.mod_act),
		.add_in      (res1),
		.res_nxt_out (res2),
		.carry_out   (c2)
	);

	fni_accum u_acc3 (
		.clk_in      (MCLK_IN),
		.rst_n_in    (NRST_IN),
		.clr_in      (st_q.load),
		.step_in     (st_q.tick),
		.modulus_in  (st_q.mod_act),
		.add_in      (stage3_add),
		.res_nxt_out (res3),
		.carry_out   (c3)
	);

	// The dither word restarts with each setting so a channel repeats its pattern
	fni_lfsr u_dither (
		.clk_in   (MCLK_IN),
		.rst_n_in (NRST_IN),
		.clr_in   (st_q.load),
		.step_in  (st_q.tick),
		.en_in    (dither_en),
		.bit_out  (dither_bit)
	);

	always_comb
	begin
		st_d = st_q;
		st_d.tick = 1'b0;
		st_d.load = 1'b0;
		wr_fire = 1'b0;

		// Fastlock overrides the programmed current, and closes the switch only when the mux selects the switch function
		cp_eff = st_q.fastlock ? `FNI_CP_MAX : st_q.cp_set;
		sw_closed = st_q.fastlock && (st_q.mux_sel == fni_pkg::FNI_MUX_FLSW);

		// Write channel: address and data taken in either order
		S_AXI_AWREADY_OUT = !st_q.aw_ok && !st_q.bvalid;
		S_AXI_WREADY_OUT = !st_q.w_ok && !st_q.bvalid;
		if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
		begin
			st_d.aw_ok = 1'b1;
			st_d.aw_addr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
		begin
			st_d.w_ok = 1'b1;
			st_d.w_data = S_AXI_WDATA_IN;
			st_d.w_strb = S_AXI_WSTRB_IN;
		end
		if (st_q.bvalid && S_AXI_BREADY_IN)
			st_d.bvalid = 1'b0;

		for (int i = 0; i < 4; i++)
			wmask[i * 8 +: 8] = {8{st_q.w_strb[i]}};

		rd_word = 32'h0000_0000;
		merged = 32'h0000_0000;
		mod_load = (st_q.mod_pend < `FNI_MOD_MIN) ? `FNI_MOD_MIN : st_q.mod_pend;

		if (st_q.aw_ok && st_q.w_ok)
		begin
			wr_fire = 1'b1;
			st_d.aw_ok = 1'b0;
			st_d.w_ok = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = `FNI_RESP_OKAY;
			case (st_q.aw_addr)
				`FNI_ADDR_NDIV:
				begin
					merged = (st_q.w_data & wmask) |
						({st_q.fastlock, 3'h0, st_q.fractional_numerator, st_q.int_div} & ~wmask);
					st_d.int_div = merged[`FNI_NDIV_INT_LSB +: 16];
					st_d.fractional_numerator = merged[`FNI_NDIV_FRACTIONAL_NUMERATOR_LSB +: 12];
					st_d.fastlock = merged[`FNI_NDIV_FL_BIT];
					// A pending modulus only takes effect with a divide-setting write
					st_d.mod_act = mod_load;
					st_d.load = 1'b1;
				end
				`FNI_ADDR_RDIV:
				begin
					merged = (st_q.w_data & wmask) |
						({15'h0000, st_q.dbl, st_q.rdiv, st_q.mod_pend} & ~wmask);
					st_d.mod_pend = merged[`FNI_RDIV_MOD_LSB +: 12];
					st_d.rdiv = merged[`FNI_RDIV_R_LSB +: 4];
					st_d.dbl = merged[`FNI_RDIV_DBL_BIT];
				end
				`FNI_ADDR_CTRL:
				begin
					merged = (st_q.w_data & wmask) |
						({24'h000000, st_q.mode, st_q.mux_sel, st_q.cp_set} & ~wmask);
					st_d.cp_set = merged[`FNI_CTRL_CP_LSB +: 4];
					st_d.mux_sel = fni_pkg::fni_mux_t'(merged[`FNI_CTRL_MUX_LSB +: 2]);
					st_d.mode = fni_pkg::fni_mode_t'(merged[`FNI_CTRL_MODE_LSB +: 2]);
				end
				`FNI_ADDR_STAT:
					st_d.bresp = `FNI_RESP_OKAY;
				default:
					st_d.bresp = `FNI_RESP_SLVERR;
			endcase
		end

		// Read channel: one-cycle answer from a register
		S_AXI_ARREADY_OUT = !st_q.rvalid;
		rd_hit = 1'b1;
		case (S_AXI_ARADDR_IN)
			`FNI_ADDR_NDIV:
				rd_word = {st_q.fastlock, 3'h0, st_q.fractional_numerator, st_q.int_div};
			`FNI_ADDR_RDIV:
				rd_word = {15'h0000, st_q.dbl, st_q.rdiv, st_q.mod_pend};
			`FNI_ADDR_CTRL:
				rd_word = {24'h000000, st_q.mode, st_q.mux_sel, st_q.cp_set};
			`FNI_ADDR_STAT:
				rd_word = {st_q.ratio, 10'h000, dither_en, sw_closed, cp_eff};
			default:
				rd_hit = 1'b0;
		endcase
		if (st_q.rvalid && S_AXI_RREADY_IN)
			st_d.rvalid = 1'b0;
		if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
		begin
			st_d.rvalid = 1'b1;
			st_d.rdata = rd_word;
			st_d.rresp = rd_hit ? `FNI_RESP_OKAY : `FNI_RESP_SLVERR;
		end

		// Reference edges: falling edge only, or both edges when doubled
		st_d.ref_prev = REFERENCE_INPUT_IN;
		if (st_q.dbl)
			ref_event = st_q.ref_prev ^ REFERENCE_INPUT_IN;
		else
			ref_event = st_q.ref_prev && !REFERENCE_INPUT_IN;

		// Divide ratio 0 is treated as 1 so the detector clock never stops
		rdiv_eff = (st_q.rdiv == 4'h0) ? 4'h1 : st_q.rdiv;
		if (ref_event)
		begin
			if (st_q.rcnt + 4'h1 >= rdiv_eff)
			begin
				st_d.rcnt = 4'h0;
				st_d.tick = 1'b1;
			end
			else
				st_d.rcnt = st_q.rcnt + 4'h1;
		end

		// Noise-shaped sum: c1 + (1-z)c2 + (1-z)^2 c3, range -3 to +4
		ysum = 5'(c1) + 5'(c2) - 5'(st_q.c2z) + 5'(c3)
			- 5'({st_q.c3z, 1'b0}) + 5'(st_q.c3zz);
		if (st_q.load)
		begin
			st_d.c2z = 1'b0;
			st_d.c3z = 1'b0;
			st_d.c3zz = 1'b0;
			st_d.ratio = st_q.int_div;
		end
		else if (st_q.tick)
		begin
			st_d.c2z = c2;
			st_d.c3z = c3;
			st_d.c3zz = st_q.c3z;
			st_d.ratio = st_q.int_div + {{11{ysum[4]}}, ysum};
		end
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (!NRST_IN)
		begin
			st_q <= '0;
			st_q.int_div <= `FNI_INT_RST;
			st_q.fractional_numerator <= `FNI_FRACTIONAL_NUMERATOR_RST;
			st_q.mod_act <= `FNI_MOD_RST;
			st_q.mod_pend <= `FNI_MOD_RST;
			st_q.rdiv <= `FNI_R_RST;
			st_q.cp_set <= `FNI_CP_RST;
			st_q.ratio <= `FNI_INT_RST;
			st_q.mux_sel <= fni_pkg::FNI_MUX_LOW;
			st_q.mode <= fni_pkg::FNI_LOWEST_NOISE;
		end
		else
			st_q <= st_d;
	end

	assign S_AXI_BVALID_OUT = st_q.bvalid;
	assign S_AXI_BRESP_OUT = st_q.bresp;
	assign S_AXI_RVALID_OUT = st_q.rvalid;
	assign S_AXI_RDATA_OUT = st_q.rdata;
	assign S_AXI_RRESP_OUT = st_q.rresp;
	assign DIV_RATIO_OUT = st_q.ratio;
	assign PFD_TICK_OUT = st_q.tick;

	// Current and switch are registered so the analog side sees clean levels
	logic [3:0] cp_out_q;
	logic       sw_out_q;
	logic       mux_out_q;
	logic       mux_d;

	always_comb
	begin
		case (st_q.mux_sel)
			fni_pkg::FNI_MUX_PFD:
				mux_d = st_q.tick;
			fni_pkg::FNI_MUX_FLSW:
				mux_d = sw_closed;
			fni_pkg::FNI_MUX_DITHER:
				mux_d = dither_bit;
			default:
				mux_d = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (!NRST_IN)
		begin
			cp_out_q <= `FNI_CP_RST;
			sw_out_q <= 1'b0;
			mux_out_q <= 1'b0;
		end
		else
		begin
			cp_out_q <= cp_eff;
			sw_out_q <= sw_closed;
			mux_out_q <= mux_d;
		end
	end

	assign CP_CURRENT_OUT = cp_out_q;
	assign FL_SWITCH_OUT = sw_out_q;
	assign MULTIPLEXED_OUTPUT_OUT = mux_out_q;

	default clocking cb_main @(posedge MCLK_IN);
	endclocking
	default disable iff (!NRST_IN);

	a_mod_range: assert property (st_q.mod_act >= `FNI_MOD_MIN)
		else $error("active modulus below two");

	a_step_rate: assert property (!st_q.tick && !st_q.load |=> $stable(DIV_RATIO_OUT))
		else $error("divide ratio moved without a detector tick");

	a_ratio_span: assert property (st_q.tick && !st_q.load |=>
		(16'(DIV_RATIO_OUT - $past(st_q.int_div)) <= 16'h0004) ||
		(16'($past(st_q.int_div) - DIV_RATIO_OUT) <= 16'h0003))
		else $error("divide ratio outside integer part -3 to +4");

	a_dither_mode: assert property (
		(st_q.mode != fni_pkg::FNI_LOW_SPUR) |-> stage3_add == res2)
		else $error("dither injected outside low spur mode");

	a_fast_current: assert property (st_q.fastlock |=> CP_CURRENT_OUT == `FNI_CP_MAX)
		else $error("fastlock did not force maximum current");

	a_switch_close: assert property (
		st_q.fastlock && st_q.mux_sel == fni_pkg::FNI_MUX_FLSW |=>
		FL_SWITCH_OUT && MULTIPLEXED_OUTPUT_OUT)
		else $error("fastlock switch not closed");

	a_fast_release: assert property ($fell(st_q.fastlock) |=>
		!FL_SWITCH_OUT && CP_CURRENT_OUT == $past(st_q.cp_set))
		else $error("fastlock release did not restore current");

	a_doubler_edge: assert property (st_q.dbl && st_q.rcnt + 4'h1 == st_q.rdiv &&
		$rose(REFERENCE_INPUT_IN) |=> st_q.tick)
		else $error("doubled reference missed a rising edge");

	a_bypass_edge: assert property (
		!st_q.dbl && $rose(REFERENCE_INPUT_IN) |=> !st_q.tick)
		else $error("rising edge counted with doubler bypassed");

	a_rdiv_count: assert property (st_q.tick |-> st_q.rcnt == 4'h0)
		else $error("reference counter not restarted on a tick");

	a_load_restart: assert property (st_q.load |=>
		u_acc1.st_q.res == 12'h000 && u_acc3.st_q.res == 12'h000 &&
		u_dither.st_q.sr == `FNI_LFSR_SEED && !st_q.c3z)
		else $error("modulator not restarted after a new setting");

	a_write_load: assert property (wr_fire && st_q.aw_addr == `FNI_ADDR_NDIV |=> st_q.load)
		else $error("divide-setting write did not load the modulator");
endmodule

// ---- inc/fni_defines.svh ----
// Register map, field positions, reset values and constants of the interpolator block
`ifndef FNI_DEFINES_SVH
`define FNI_DEFINES_SVH

`define FNI_ADDR_NDIV      8'h00
`define FNI_ADDR_RDIV      8'h04
`define FNI_ADDR_CTRL      8'h08
`define FNI_ADDR_STAT      8'h0c

`define FNI_NDIV_INT_LSB   0
`define FNI_NDIV_FRACTIONAL_NUMERATOR_LSB  16
`define FNI_NDIV_FL_BIT    31
`define FNI_RDIV_MOD_LSB   0
`define FNI_RDIV_R_LSB     12
`define FNI_RDIV_DBL_BIT   16
`define FNI_CTRL_CP_LSB    0
`define FNI_CTRL_MUX_LSB   4
`define FNI_CTRL_MODE_LSB  6
`define FNI_STAT_CP_LSB    0
`define FNI_STAT_SW_BIT    4
`define FNI_STAT_DITH_BIT  5
`define FNI_STAT_RATIO_LSB 16

`define FNI_INT_RST        16'h0040
`define FNI_FRACTIONAL_NUMERATOR_RST       12'h000
`define FNI_MOD_RST        12'h064
`define FNI_MOD_MIN        12'h002
`define FNI_R_RST          4'h1
`define FNI_CP_RST         4'h0
`define FNI_CP_MAX         4'hf
`define FNI_LFSR_SEED      21'h000001

`define FNI_RESP_OKAY      2'h0
`define FNI_RESP_SLVERR    2'h2

`endif

// ---- inc/fni_pkg.sv ----
// Types shared by the interpolator modules
package fni_pkg;

	typedef enum logic [1:0] {
		FNI_LOWEST_NOISE = 2'h0,
		FNI_NOISE_SPUR   = 2'h1,
		FNI_LOW_SPUR     = 2'h2
	} fni_mode_t;

	typedef enum logic [1:0] {
		FNI_MUX_LOW    = 2'h0,
		FNI_MUX_PFD    = 2'h1,
		FNI_MUX_FLSW   = 2'h2,
		FNI_MUX_DITHER = 2'h3
	} fni_mux_t;

	typedef struct packed {
		logic [11:0] res;
	} fni_acc_state_t;

	typedef struct packed {
		logic [20:0] sr;
	} fni_lfsr_state_t;

	typedef struct packed {
		logic        aw_ok;
		logic [7:0]  aw_addr;
		logic        w_ok;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] int_div;
		logic [11:0] fractional_numerator;
		logic        fastlock;
		logic [11:0] mod_act;
		logic [11:0] mod_pend;
		logic [3:0]  rdiv;
		logic        dbl;
		logic [3:0]  cp_set;
		fni_mux_t    mux_sel;
		fni_mode_t   mode;
		logic        ref_prev;
		logic [3:0]  rcnt;
		logic        tick;
		logic        load;
		logic        c2z;
		logic        c3z;
		logic        c3zz;
		logic [15:0] ratio;
	} fni_top_state_t;

endpackage

// ---- hw/fni_accum.sv ----
// One modulo accumulator stage of the cascaded modulator
`timescale 1ns/1ps
module fni_accum (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        clr_in,
	input  wire logic        step_in,
	input  wire logic [11:0] modulus_in,
	input  wire logic [11:0] add_in,
	output logic      [11:0] res_nxt_out,
	output logic             carry_out
);
	fni_pkg::fni_acc_state_t st_q;
	fni_pkg::fni_acc_state_t st_d;
	logic [12:0]             sum;

	always_comb
	begin
		sum = {1'b0, st_q.res} + {1'b0, add_in};
		carry_out = (sum >= {1'b0, modulus_in});
		res_nxt_out = carry_out ? 12'(sum - {1'b0, modulus_in}) : sum[11:0];
		st_d = st_q;
		// Clear beats a step so a new setting always starts from zero
		if (clr_in)
			st_d.res = 12'h000;
		else if (step_in)
			st_d.res = res_nxt_out;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule

// ---- hw/fni_lfsr.sv ----
// Dither source: maximal length shift register of 21 bits
`timescale 1ns/1ps
`include "fni_defines.svh"
module fni_lfsr (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic clr_in,
	input  wire logic step_in,
	input  wire logic en_in,
	output logic      bit_out
);
	fni_pkg::fni_lfsr_state_t st_q;
	fni_pkg::fni_lfsr_state_t st_d;

	always_comb
	begin
		st_d = st_q;
		if (clr_in)
			st_d.sr = `FNI_LFSR_SEED;
		else if (step_in)
			st_d.sr = {st_q.sr[19:0], st_q.sr[20] ^ st_q.sr[18]};
		bit_out = st_q.sr[0] & en_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			st_q.sr <= `FNI_LFSR_SEED;
		else
			st_q <= st_d;
	end
endmodule

// ---- dv/fni_host.sv ----
// Host controller model: AXI4-Lite master that programs the synthesizer registers
`timescale 1ns/1ps
module fni_host (
	input  wire logic        clk_in,
	output logic      [7:0]  awaddr_out,
	output logic             awvalid_out,
	input  wire logic        awready_in,
	output logic      [31:0] wdata_out,
	output logic             wvalid_out,
	input  wire logic        wready_in,
	input  wire logic [1:0]  bresp_in,
	input  wire logic        bvalid_in,
	output logic             bready_out,
	output logic      [7:0]  araddr_out,
	output logic             arvalid_out,
	input  wire logic        arready_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic [1:0]  rresp_in,
	input  wire logic        rvalid_in,
	output logic             rready_out
);
	initial
	begin
		awaddr_out = 8'h00;
		awvalid_out = 1'b0;
		wdata_out = 32'h0;
		wvalid_out = 1'b0;
		bready_out = 1'b0;
		araddr_out = 8'h00;
		arvalid_out = 1'b0;
		rready_out = 1'b0;
	end

	// Address and data go out together; each is dropped on its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk_in);
		awaddr_out <= a;
		awvalid_out <= 1'b1;
		wdata_out <= d;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge clk_in);
			if (!aw && awready_in === 1'b1)
			begin
				aw = 1'b1;
				awvalid_out <= 1'b0;
			end
			if (!w && wready_in === 1'b1)
			begin
				w = 1'b1;
				wvalid_out <= 1'b0;
			end
		end
		do
			@(posedge clk_in);
		while (bvalid_in !== 1'b1);
		r = bresp_in;
		bready_out <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		do
			@(posedge clk_in);
		while (arready_in !== 1'b1);
		arvalid_out <= 1'b0;
		do
			@(posedge clk_in);
		while (rvalid_in !== 1'b1);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
	endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the fractional-N interpolator
`timescale 1ns/1ps
module tb;
	logic        mclk;
	logic        nrst;
	logic        ref_clk;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [15:0] ratio;
	logic [3:0]  cp;
	logic [1:0]  bresp, rresp, rs;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pfd, sw, mux;
	logic [15:0] s [0:199];
	logic [15:0] first [0:9];
	int          mismatches = 0;
	int          total_checks = 0;
	int          cyc = 0;

	localparam int RV [5] = '{1, 3, 2, 4, 15};
	localparam int DV [5] = '{0, 0, 1, 1, 0};
	localparam int PV [5] = '{8, 24, 8, 16, 120};
	localparam logic [11:0] MV [6] = '{12'h005, 12'h002, 12'h004, 12'h009, 12'h006, 12'h005};
	localparam int LV [6] = '{5, 4, 8, 27, 36, 5};

	fni_top fni_top_i (
		.MCLK_IN(mclk), .NRST_IN(nrst),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .REFERENCE_INPUT_IN(ref_clk),
		.DIV_RATIO_OUT(ratio), .PFD_TICK_OUT(pfd), .CP_CURRENT_OUT(cp),
		.FL_SWITCH_OUT(sw), .MULTIPLEXED_OUTPUT_OUT(mux)
	);

	fni_host host_i (
		.clk_in(mclk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
		.wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
		.bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
		.arready_in(arready), .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
		.rready_out(rready)
	);

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Reference toggles every 4 cycles: 31.25 MHz at the detector with R=1 or doubler and R=2
	initial
	begin
		ref_clk = 1'b1;
		forever
		begin
			repeat (4) @(posedge mclk);
			ref_clk <= ~ref_clk;
		end
	end

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// Returns one cycle after the n-th detector tick, when the new ratio stands
	task automatic wait_tick(input int n);
		repeat (n)
		begin
			do
				@(posedge mclk);
			while (pfd !== 1'b1);
		end
		@(posedge mclk);
		#1;
	endtask

	task automatic capture(input int l, output int bad, output int sum);
		bad = 0;
		sum = 0;
		wait_tick(4);
		for (int i = 0; i < 2 * l; i++)
		begin
			wait_tick(1);
			s[i] = ratio;
		end
		for (int i = 0; i < l; i++)
		begin
			if (s[i] !== s[i + l])
				bad++;
			sum += int'(s[i]) - 100;
		end
	endtask

	task automatic t_reset;
		chk(ratio === 16'h0040 && cp === 4'h0 && sw === 1'b0 && mux === 1'b0, "outputs reset");
		host_i.rd(8'h00, rd_d, rs);
		chk(rd_d === 32'h0000_0040 && rs === 2'h0, "ndiv reset");
		host_i.rd(8'h04, rd_d, rs);
		chk(rd_d === 32'h0000_1064, "rdiv reset");
		host_i.rd(8'h08, rd_d, rs);
		chk(rd_d === 32'h0, "ctrl reset");
		host_i.rd(8'h10, rd_d, rs);
		chk(rs === 2'h2 && rd_d === 32'h0, "unmapped read");
		host_i.wr(8'h10, 32'hffff_ffff, rs);
		chk(rs === 2'h2, "unmapped write");
		host_i.wr(8'h0c, 32'hffff_ffff, rs);
		host_i.rd(8'h0c, rd_d, rs);
		chk(rd_d === 32'h0040_0000, "status read-only");
	endtask

	task automatic t_refdiv;
		int t0;
		for (int i = 0; i < 5; i++)
		begin
			host_i.wr(8'h04, {15'h0, 1'(DV[i]), 4'(RV[i]), 12'h064}, rs);
			wait_tick(2);
			t0 = cyc;
			wait_tick(1);
			chk(cyc - t0 == PV[i], "detector period");
		end
	endtask

	task automatic t_seq;
		int bad;
		int sum;
		for (int i = 0; i < 6; i++)
		begin
			host_i.wr(8'h04, {4'h0, 16'h0001, MV[i]}, rs);
			host_i.wr(8'h00, 32'h0001_0064, rs);
			capture(LV[i], bad, sum);
			chk(bad == 0, "repeat length");
			chk(sum == LV[i] / MV[i], "average ratio");
			for (int k = 0; k < 10; k++)
			begin
				if (i == 0)
					first[k] = s[k];
				else if (i == 5)
					chk(s[k] === first[k], "same channel sequence");
			end
		end
	endtask

	task automatic t_dither;
		int bad;
		int sum;
		host_i.wr(8'h04, 32'h0000_1032, rs);
		for (int m = 0; m < 4; m++)
		begin
			host_i.wr(8'h08, (32'(m) << 6) | 32'h0000_0030, rs);
			host_i.rd(8'h0c, rd_d, rs);
			chk(rd_d[5] === (m == 2), "dither enable");
			chk(m == 2 || mux === 1'b0, "dither pin quiet");
		end
		host_i.wr(8'h08, 32'h0000_0080, rs);
		host_i.wr(8'h00, 32'h0001_0064, rs);
		capture(100, bad, sum);
		chk(bad > 0, "dithered sequence");
		host_i.wr(8'h08, 32'h0, rs);
	endtask

	task automatic t_fast;
		host_i.wr(8'h08, 32'h0000_0010, rs);
		do
			@(posedge mclk);
		while (pfd !== 1'b1);
		#1;
		chk(mux === 1'b1, "detector tick on mux output");
		host_i.wr(8'h08, 32'h0000_0023, rs);
		host_i.wr(8'h00, 32'h8000_0064, rs);
		repeat (2) @(posedge mclk);
		#1;
		chk(cp === 4'hf && sw === 1'b1 && mux === 1'b1, "fastlock on");
		host_i.rd(8'h0c, rd_d, rs);
		chk(rd_d[4:0] === 5'h1f, "fastlock status");
		host_i.wr(8'h00, 32'h0000_0064, rs);
		repeat (2) @(posedge mclk);
		#1;
		chk(cp === 4'h3 && sw === 1'b0 && mux === 1'b0, "fastlock off");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		nrst = 1'b0;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1;
		t_reset();
		t_refdiv();
		t_seq();
		t_dither();
		t_fast();
		wrap_up();
	end
endmodule
